// ---- rtl/irs_device.sv ----
`timescale 1ns/1ps
`include "irs_defs.svh"
// Behaviour
// - Column slot advance moves a column packet one cycle earlier; device honours it.
// - Write data fills every second cycle from cycle seven, two per bank.
// - Row-shut advance field places it earlier; device ignores the field.
// - Device returns read data every second cycle from eleven, one cycle per packet.
// - Read data leaves exactly one read data delay after its fetch column.
// - Read-to-write column gap is turnaround plus read delay minus write delay plus column time.
// - Column packets spaced by column cycle time, two cycles, twice one data packet.
module irs_device (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Request lines, decoded packet, same clock
    input wire irs_pkg::irs_req_t request_lines,
    // Write data from the data bus
    input wire irs_pkg::irs_data_t wr_data,
    // Read data driven onto the data bus
    output irs_pkg::irs_data_t rd_data,
    output logic dq_oe_b,
    // Core status
    output logic [`IRS_BANKS-1:0] bank_open,
    output logic protocol_err
);
    // ==========================================
    // Storage and local state
    logic [`IRS_DATA_W-1:0] mem_q [0:(1<<`IRS_BANK_W)-1][0:15];
    logic [`IRS_BANKS-1:0] bank_open_q;
    logic [`IRS_PIPE-1:0] fetch_pipe_q;
    logic [`IRS_PIPE-1:0] store_pipe_q;
    logic [`IRS_BANK_W+3:0] fetch_addr_q [0:`IRS_PIPE-1];
    logic [`IRS_BANK_W+3:0] store_addr_q [0:`IRS_PIPE-1];
    irs_pkg::irs_data_t rd_data_q;
    logic err_q;
    logic [3:0] col_gap_q;
    irs_pkg::irs_dir_t dir_q;
    logic [3:0] tap_rd;
    logic [3:0] tap_wr;
    logic is_col;

    // ==========================================
    // Timing summary, request clock cycles
    // Fetch sampled at edge N: rd_data valid from edge N+6
    // Advanced fetch: rd_data valid from edge N+7, the same delay counted from its intended slot
    // Store sampled at edge N: wr_data taken at edge N+6
    // Advanced store: taken at edge N+7
    // Read data stands one cycle per packet
    // Bank open state follows open and shut one edge later
    // Column gap below two cycles: protocol error
    // Store to fetch below nine cycles: protocol error
    // Fetch to store below three cycles: protocol error
    // Column to a closed bank: protocol error
    // Row-shut advance only moves the slot; no effect inside
    // No long counters; column gap count saturates at fifteen
    // Storage is eight banks of sixteen words, no reset
    // Unwritten words read back unknown

    // Column packet taps; an advanced column was sent a cycle early, so its delay is one longer
    function automatic logic [3:0] irs_tap(input logic [3:0] dly, input logic adv);
        irs_tap = adv ? dly : dly - 4'h1;
    endfunction

    // Decoded column taps and column detect
    always_comb begin
        tap_rd = irs_tap(`IRS_RD_DATA_DELAY, request_lines.column_slot_advance);
        tap_wr = irs_tap(`IRS_WR_DATA_DELAY, request_lines.column_slot_advance);
        is_col = (request_lines.kind == irs_pkg::IRS_PKT_COL_FETCH) ||
                 (request_lines.kind == irs_pkg::IRS_PKT_COL_STORE);
    end

    // ==========================================
    // Row open and shut
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            bank_open_q <= '0;
        end else begin
            // Row-shut takes effect regardless of its advance field
            case (request_lines.kind)
                irs_pkg::IRS_PKT_ROW_OPEN: bank_open_q[request_lines.bank] <= 1'b1;
                irs_pkg::IRS_PKT_ROW_SHUT: bank_open_q[request_lines.bank] <= 1'b0;
                default: bank_open_q <= bank_open_q;
            endcase
        end
    end
    assign bank_open = bank_open_q;

    // ==========================================
    // Fetch and store delay lines
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            fetch_pipe_q <= '0;
            store_pipe_q <= '0;
        end else begin
            fetch_pipe_q <= {1'b0, fetch_pipe_q[`IRS_PIPE-1:1]};
            store_pipe_q <= {1'b0, store_pipe_q[`IRS_PIPE-1:1]};
            if (request_lines.kind == irs_pkg::IRS_PKT_COL_FETCH) begin
                fetch_pipe_q[tap_rd] <= 1'b1;
            end
            if (request_lines.kind == irs_pkg::IRS_PKT_COL_STORE) begin
                store_pipe_q[tap_wr] <= 1'b1;
            end
        end
    end

    // Address delay lines shift alongside the valid bits
    genvar gi;
    generate
        for (gi = 0; gi < `IRS_PIPE; gi++) begin : g_addr
            always_ff @(posedge sys_clk) begin
                if (!rst_b) begin
                    fetch_addr_q[gi] <= '0;
                    store_addr_q[gi] <= '0;
                end else begin
                    if (request_lines.kind == irs_pkg::IRS_PKT_COL_FETCH && tap_rd == 4'(gi)) begin
                        fetch_addr_q[gi] <= {request_lines.bank, request_lines.addr[3:0]};
                    end else if (gi < `IRS_PIPE - 1) begin
                        fetch_addr_q[gi] <= fetch_addr_q[(gi + 1) % `IRS_PIPE];
                    end else begin
                        fetch_addr_q[gi] <= '0;
                    end
                    if (request_lines.kind == irs_pkg::IRS_PKT_COL_STORE && tap_wr == 4'(gi)) begin
                        store_addr_q[gi] <= {request_lines.bank, request_lines.addr[3:0]};
                    end else if (gi < `IRS_PIPE - 1) begin
                        store_addr_q[gi] <= store_addr_q[(gi + 1) % `IRS_PIPE];
                    end else begin
                        store_addr_q[gi] <= '0;
                    end
                end
            end
        end
    endgenerate

    // ==========================================
    // Write data capture
    // Store slot without valid data leaves the word untouched
    always_ff @(posedge sys_clk) begin
        if (store_pipe_q[0] && wr_data.valid) begin
            mem_q[store_addr_q[0][`IRS_BANK_W+3:4]][store_addr_q[0][3:0]] <= wr_data.data;
        end
    end

    // ==========================================
    // Read data return, one packet per column cycle
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            rd_data_q <= '0;
        end else begin
            rd_data_q.valid <= fetch_pipe_q[0];
            rd_data_q.data <= fetch_pipe_q[0] ?
                mem_q[fetch_addr_q[0][`IRS_BANK_W+3:4]][fetch_addr_q[0][3:0]] : '0;
        end
    end
    assign rd_data = rd_data_q;
    assign dq_oe_b = ~rd_data_q.valid;

    // ==========================================
    // Direction of the last column packet
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            dir_q <= irs_pkg::IRS_DIR_IDLE;
        end else if (is_col) begin
            dir_q <= (request_lines.kind == irs_pkg::IRS_PKT_COL_FETCH) ?
                irs_pkg::IRS_DIR_FETCH : irs_pkg::IRS_DIR_STORE;
        end
    end

    // Column spacing and turnaround watch, error sticky until reset
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            col_gap_q <= 4'hF;
            err_q <= 1'b0;
        end else begin
            col_gap_q <= (col_gap_q == 4'hF) ? col_gap_q : col_gap_q + 4'h1;
            if (is_col) begin
                col_gap_q <= 4'h1;
                if (col_gap_q < `IRS_COL_CYCLE) begin
                    err_q <= 1'b1;
                end
                case (dir_q)
                    irs_pkg::IRS_DIR_STORE: begin
                        if (request_lines.kind == irs_pkg::IRS_PKT_COL_FETCH &&
                            col_gap_q < `IRS_WR_TO_RD_GAP) begin
                            err_q <= 1'b1;
                        end
                    end
                    irs_pkg::IRS_DIR_FETCH: begin
                        if (request_lines.kind == irs_pkg::IRS_PKT_COL_STORE &&
                            col_gap_q < `IRS_RD_DATA_DELAY - `IRS_WR_DATA_DELAY
                                        + `IRS_COL_CYCLE + `IRS_RW_BUBBLE) begin
                            err_q <= 1'b1;
                        end
                    end
                    default: err_q <= err_q;
                endcase
            end
            if (is_col && !bank_open_q[request_lines.bank]) begin
                err_q <= 1'b1;
            end
        end
    end
    assign protocol_err = err_q;
endmodule

// ---- rtl/irs_defs.svh ----
`ifndef IRS_DEFS_SVH
`define IRS_DEFS_SVH
// Timing in request clock cycles
`define IRS_COL_CYCLE 4'h2
`define IRS_WR_DATA_DELAY 4'h6
`define IRS_RD_DATA_DELAY 4'h6
`define IRS_WR_TO_RD_GAP 4'h9
`define IRS_RW_BUBBLE 4'h1
// Request packet layout
`define IRS_BANK_W 3
`define IRS_BANKS 8
`define IRS_ADDR_W 10
`define IRS_DATA_W 16
`define IRS_PIPE 16
`endif

// ---- rtl/irs_pkg.sv ----
`include "irs_defs.svh"
package irs_pkg;
    // Request packet kinds on the request lines
    typedef enum logic [2:0] {
        IRS_PKT_NONE = 3'h0,
        IRS_PKT_ROW_OPEN = 3'h1,
        IRS_PKT_COL_STORE = 3'h2,
        IRS_PKT_COL_FETCH = 3'h3,
        IRS_PKT_ROW_SHUT = 3'h4
    } irs_pkt_kind_t;

    // Decoded request packet
    typedef struct packed {
        irs_pkt_kind_t kind;
        logic [`IRS_BANK_W-1:0] bank;
        logic [`IRS_ADDR_W-1:0] addr;
        logic column_slot_advance;
        logic [1:0] shut_advance;
    } irs_req_t;

    // Data bus word
    typedef struct packed {
        logic valid;
        logic [`IRS_DATA_W-1:0] data;
    } irs_data_t;

    // Turnaround state of the column path
    typedef enum logic [2:0] {
        IRS_DIR_IDLE = 3'b001,
        IRS_DIR_STORE = 3'b010,
        IRS_DIR_FETCH = 3'b100
    } irs_dir_t;
endpackage

// ---- tb/irs_device_checker.sv ----
`timescale 1ns/1ps
// ====================
// Port checker
module irs_device_checker (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Device ports
    input wire irs_pkg::irs_req_t request_lines,
    input wire irs_pkg::irs_data_t rd_data,
    input wire logic dq_oe_b,
    input wire logic [7:0] bank_open,
    input wire logic protocol_err
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // Decoded request kinds
    wire [2:0] kd = request_lines.kind;
    wire fn = kd == 3'h3 && !request_lines.column_slot_advance;
    wire fa = kd == 3'h3 && request_lines.column_slot_advance;
    wire col = kd == 3'h2 || kd == 3'h3;
    rd_delay_a: assert property (fn |-> ##7 rd_data.valid) else $error("read late");
    adv_delay_a: assert property (fa |-> ##8 rd_data.valid) else $error("advanced read late");
    rd_cause_a: assert property (rd_data.valid |-> $past(fn, 7) || $past(fa, 8)) else $error("stray read");
    oe_pair_a: assert property (dq_oe_b == !rd_data.valid) else $error("enable mismatch");
    rd_pulse_a: assert property (rd_data.valid |=> !rd_data.valid) else $error("long packet");
    gap_err_a: assert property (col ##1 col |-> ##[0:1] protocol_err) else $error("gap missed");
    err_hold_a: assert property (protocol_err |=> protocol_err) else $error("error dropped");
    open_set_a: assert property (kd == 3'h1 |=> bank_open[$past(request_lines.bank)]) else $error("open lost");
    shut_clr_a: assert property (kd == 3'h4 |=> !bank_open[$past(request_lines.bank)]) else $error("shut lost");
endmodule
bind irs_device irs_device_checker chk (.sys_clk, .rst_b, .request_lines, .rd_data, .dq_oe_b, .bank_open, .protocol_err);

// ---- tb/irs_ctrl_model.sv ----
`timescale 1ns/1ps
// ====================
// Interleaved page-empty controller
module irs_ctrl_model (
    // Clock and stream control
    input wire logic sys_clk,
    input wire logic go,
    input wire logic rd_mode,
    // Request and write data buses
    output irs_pkg::irs_req_t req,
    output irs_pkg::irs_data_t wd
);
    int t = -1;
    int n;
    int k;
    int s;
    initial req = '0;
    initial wd = '0;
    // Slot allocator, one packet per request slot
    always @(negedge sys_clk) begin
        t = go ? t + 1 : -1;
        n = rd_mode ? 16 : 20;
        k = t - (rd_mode ? 5 : 1);
        s = t - (rd_mode ? 10 : 14);
        req <= '0;
        wd.valid <= 1'b0;
        wd.data <= ~wd.data; // Released bus keeps toggling
        if (t >= 0 && t % 4 == 0 && t < n)
            req <= '{irs_pkg::IRS_PKT_ROW_OPEN, 3'(t / 4), 10'h0, 1'b0, 2'h0};
        if (k >= 0 && k % 2 == 0 && k < n)
            req <= '{rd_mode ? irs_pkg::IRS_PKT_COL_FETCH : irs_pkg::IRS_PKT_COL_STORE,
                3'(k / 4), 10'(k / 2 % 2 + 1), 1'b0, 2'h0};
        if (s >= 0 && s % 4 == 0 && s < n)
            req <= '{irs_pkg::IRS_PKT_ROW_SHUT, 3'(s / 4), 10'h0, 1'b0, 2'h0};
        if (!rd_mode && k >= 6 && k % 2 == 0 && k < n + 6)
            wd <= '{1'b1, {4'hC, 1'h0, 3'((k - 6) / 4), 4'h0, 4'((k - 6) / 2 % 2 + 1)}};
    end
endmodule

// ---- tb/interleaved_request_scheduling_tb.sv ----
`timescale 1ns/1ps
// ====================
// Bench top
module interleaved_request_scheduling_tb;
    logic sys_clk = 0;
    logic rst_b = 0;
    logic go = 0;
    logic rd_mode = 0;
    logic sel = 0;
    int mismatches = 0;
    int compares = 0;
    int c;
    int last;
    irs_pkg::irs_req_t mreq;
    irs_pkg::irs_req_t treq = '0;
    irs_pkg::irs_req_t request_lines;
    irs_pkg::irs_data_t wr_data;
    irs_pkg::irs_data_t rd_data;
    logic dq_oe_b;
    logic [7:0] bank_open;
    logic protocol_err;
    // Read words expected in stream order
    logic [15:0] rows [8] = '{16'hC001, 16'hC002, 16'hC101, 16'hC102, 16'hC201, 16'hC202, 16'hC301, 16'hC302};
    // First kind, second kind, gap, error expected
    int tr [5][4] = '{'{2, 3, 8, 1}, '{2, 3, 9, 0}, '{3, 2, 2, 1}, '{3, 2, 3, 0}, '{3, 3, 1, 1}};
    always #50 sys_clk = ~sys_clk;
    assign request_lines = sel ? treq : mreq;
    irs_ctrl_model ctl (.sys_clk, .go, .rd_mode, .req(mreq), .wd(wr_data));
    irs_device uut (.sys_clk, .rst_b, .request_lines, .wr_data, .rd_data, .dq_oe_b, .bank_open, .protocol_err);
    task stop_test;
        if (mismatches == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task send(input int k, input int b, input logic a);
        treq <= '{irs_pkg::irs_pkt_kind_t'(3'(k)), 3'(b), 10'h1, a, 2'h0};
        @(negedge sys_clk);
    endtask
    task idle(input int n);
        if (n > 0) begin
            treq <= '0;
            repeat (n) @(negedge sys_clk);
        end
    endtask
    task rst(input int n);
        rst_b <= 0;
        repeat (n) @(negedge sys_clk);
        rst_b <= 1;
        @(negedge sys_clk);
        chk({bank_open, 6'h0, dq_oe_b, protocol_err}, 16'h0002);
    endtask
    // Streams, then advanced fetch, then turnaround table
    initial begin
        @(negedge sys_clk);
        rst(12);
        go <= 1;
        repeat (40) @(negedge sys_clk);
        go <= 0;
        rd_mode <= 1;
        @(negedge sys_clk);
        go <= 1;
        c = 0;
        for (int i = 0; i < 8; i++) begin
            while (rd_data.valid !== 1'b1 && c < 40) begin
                @(negedge sys_clk);
                c++;
            end
            chk(rd_data.data, rows[i]);
            chk(16'(c), 16'(i == 0 ? 13 : last + 2));
            last = c;
            @(negedge sys_clk);
            c++;
        end
        chk({bank_open, 7'h0, protocol_err}, 16'h0);
        go <= 0;
        sel <= 1;
        send(1, 4, 0);
        send(3, 4, 1);
        idle(6);
        chk({15'h0, rd_data.valid}, 16'h0);
        idle(1);
        chk(rd_data.data, 16'hC401);
        chk({14'h0, dq_oe_b, protocol_err}, 16'h0);
        for (int i = 0; i < 5; i++) begin
            rst(1);
            send(1, 3, 0);
            send(1, 4, 0);
            send(tr[i][0], 3, 0);
            idle(tr[i][2] - 1);
            send(tr[i][1], 3 + i % 2, 0);
            idle(3);
            chk({15'h0, protocol_err}, 16'(tr[i][3]));
        end
        stop_test;
    end
    // Watchdog
    initial begin
        #100000;
        mismatches++;
        stop_test;
    end
endmodule
